// file: ocdio_cfg.svh
// Register map, reset values, field positions and the operation summary
//
// Operation
// - Twenty-four channels as three eight-bit ports; A is 7..0, C is 23..16.
// - Writing one to a port bit turns that channel's driver off.
// - Each port register latches the written byte; it drives the channels.
// - A latched zero enables the driver, pulling the channel low.
// - Port read returns live level where latched one, zero where latched zero.
// - Card reset loads all three port registers with all ones.
// - A Port C channel interrupts only when latched one and enabled.
// - Four detect modes: low level, high level, falling edge, rising edge.
// - Upper and lower Port C nibbles have separate mode fields.
// - Detected conditions set sticky status bits that keep accumulating.
// - Status clears only on acknowledge one with the condition gone.
// - After any acknowledge, interrupt re-raises while status is nonzero.
// - A persisting level source keeps its status set through the acknowledge.
// - External input has the same modes, enable, status and acknowledge.
// - Ports at 0..2, enable at 5, mode at 6, status/ack at 7.
// - Mode codes: 00 low, 01 high, 10 falling, 11 rising.
// - Mode reg: bit7 ext status/ack, 6 ext enable, 5:4, 3:2, 1:0 modes.
// - Enable bit n enables Port C source n.
`ifndef OCDIO_CFG_SVH
`define OCDIO_CFG_SVH
`define OCDIO_OFS_PORT_A  3'h0
`define OCDIO_OFS_PORT_B  3'h1
`define OCDIO_OFS_PORT_C  3'h2
`define OCDIO_OFS_IRQ_EN  3'h5
`define OCDIO_OFS_MODE    3'h6
`define OCDIO_OFS_STATUS  3'h7
`define OCDIO_OFS_HOLE_LO 3'h3
`define OCDIO_OFS_HOLE_HI 3'h4
`define OCDIO_PORT_RST    8'hff
`define OCDIO_EN_RST      8'h00
`define OCDIO_MODE_RST    8'h00
`define OCDIO_EXT_STAT_B  7
`define OCDIO_EXT_EN_B    6
`define OCDIO_EXT_MODE_LO 4
`define OCDIO_UP_MODE_LO  2
`define OCDIO_LO_MODE_LO  0
`endif

// file: ocdio_pkg.sv
// Types shared by the digital I/O block
package ocdio_pkg;
   typedef enum logic [1:0] {
      OCDIO_LVL_LOW, OCDIO_LVL_HIGH, OCDIO_EDGE_FALL, OCDIO_EDGE_RISE
   } ocdio_mode_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } ocdio_bus_s;

   typedef struct packed {
      logic [7:0] port_a_r;
      logic [7:0] port_b_r;
      logic [7:0] port_c_r;
      logic [7:0] irq_en_r;
      logic       ext_en_r;
      logic [1:0] ext_mode_r;
      logic [1:0] up_mode_r;
      logic [1:0] lo_mode_r;
      logic [7:0] pend_r;
      logic       ext_pend_r;
      logic [8:0] prev_r;
      logic [7:0] rdata_r;
   } ocdio_state_s;
endpackage : ocdio_pkg

// file: ocdio_top.sv
// Twenty-four channel open-collector I/O block with Port C interrupts
`timescale 1ns/1ps
`include "ocdio_cfg.svh"
module ocdio_top #(
   parameter int PORT_W  = 8,
   parameter int N_PORTS = 3
) (
   // Clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   // Host register port
   input  wire ocdio_pkg::ocdio_bus_s i_bus,
   output logic [7:0]             o_rdata,
   output logic                   o_irq,
   // Channel pins: A 7..0, B 15..8, C 23..16
   input  wire logic [23:0]       i_io_channels,
   output logic [23:0]            o_io_channels,
   output logic [23:0]            o_io_channels_oe_n,
   // External interrupt pin
   input  wire logic              i_ext_irq
);
   import ocdio_pkg::*;

   // Only three byte-wide ports are served by the register map
   if (PORT_W != 8 || N_PORTS != 3) begin : g_bad_geometry
      $error("unsupported port geometry");
   end

   ocdio_state_s st_r;
   ocdio_state_s st_nxt;
   logic [8:0]   meta_r;
   logic [8:0]   sync_r;
   logic [23:0]  live;
   logic [7:0]   live_c;
   logic [8:0]   cond;
   logic [8:0]   src_on;
   logic [8:0]   ack;
   logic [23:0]  latch;

   // Detect condition for one source given its mode field
   function automatic logic detect(input logic [1:0] m, input logic cur,
                                   input logic prv);
      unique case (ocdio_mode_e'(m))
         OCDIO_LVL_LOW:   detect = !cur;
         OCDIO_LVL_HIGH:  detect = cur;
         OCDIO_EDGE_FALL: detect = prv && !cur;
         OCDIO_EDGE_RISE: detect = !prv && cur;
      endcase
   endfunction : detect

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge i_clk_sys) begin
      meta_r <= {i_ext_irq, i_io_channels[23:16]};
      sync_r <= meta_r;
   end

   logic [15:0] meta_ab_r;
   logic [15:0] sync_ab_r;
   always_ff @(posedge i_clk_sys) begin
      meta_ab_r <= i_io_channels[15:0];
      sync_ab_r <= meta_ab_r;
   end

   assign live   = {sync_r[7:0], sync_ab_r};
   assign live_c = sync_r[7:0];
   assign latch  = {st_r.port_c_r, st_r.port_b_r, st_r.port_a_r};

   ////////////////////////////////////////////////////////////////////////
   // Open-collector drivers: oe low drives the pin low
   assign o_io_channels      = '0;
   assign o_io_channels_oe_n = latch;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt detection
   generate
      for (genvar g = 0; g < 8; g++) begin : g_src
         assign cond[g] = detect(g < 4 ? st_r.lo_mode_r : st_r.up_mode_r,
                                 live_c[g], st_r.prev_r[g]);
         assign src_on[g] = st_r.port_c_r[g] && st_r.irq_en_r[g];
      end
   endgenerate
   assign cond[8]   = detect(st_r.ext_mode_r, sync_r[8],
                             st_r.prev_r[8]);
   assign src_on[8] = st_r.ext_en_r;

   always_comb begin
      ack = '0;
      if (i_bus.wr && i_bus.addr == `OCDIO_OFS_STATUS)
         ack[7:0] = i_bus.wdata;
      if (i_bus.wr && i_bus.addr == `OCDIO_OFS_MODE)
         ack[8] = i_bus.wdata[`OCDIO_EXT_STAT_B];
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [8:0] set;
      logic [8:0] pend;
      set    = cond & src_on;
      pend   = {st_r.ext_pend_r, st_r.pend_r};
      st_nxt = st_r;
      st_nxt.prev_r = sync_r;
      // Set wins over acknowledge; clear only if condition gone
      pend = (pend & ~(ack & ~cond)) | set;
      st_nxt.pend_r     = pend[7:0];
      st_nxt.ext_pend_r = pend[8];
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            `OCDIO_OFS_PORT_A: st_nxt.port_a_r = i_bus.wdata;
            `OCDIO_OFS_PORT_B: st_nxt.port_b_r = i_bus.wdata;
            `OCDIO_OFS_PORT_C: st_nxt.port_c_r = i_bus.wdata;
            `OCDIO_OFS_IRQ_EN: st_nxt.irq_en_r = i_bus.wdata;
            `OCDIO_OFS_MODE: begin
               st_nxt.ext_en_r   = i_bus.wdata[`OCDIO_EXT_EN_B];
               st_nxt.ext_mode_r = i_bus.wdata[`OCDIO_EXT_MODE_LO +: 2];
               st_nxt.up_mode_r  = i_bus.wdata[`OCDIO_UP_MODE_LO +: 2];
               st_nxt.lo_mode_r  = i_bus.wdata[`OCDIO_LO_MODE_LO +: 2];
            end
            default: ;
         endcase
      end
      st_nxt.rdata_r = st_r.rdata_r;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `OCDIO_OFS_PORT_A: st_nxt.rdata_r = live[7:0] & latch[7:0];
            `OCDIO_OFS_PORT_B: st_nxt.rdata_r = live[15:8] & latch[15:8];
            `OCDIO_OFS_PORT_C: st_nxt.rdata_r = live[23:16] & latch[23:16];
            `OCDIO_OFS_IRQ_EN: st_nxt.rdata_r = st_r.irq_en_r;
            `OCDIO_OFS_MODE:   st_nxt.rdata_r = {st_r.ext_pend_r,
               st_r.ext_en_r, st_r.ext_mode_r, st_r.up_mode_r,
               st_r.lo_mode_r};
            `OCDIO_OFS_STATUS: st_nxt.rdata_r = st_r.pend_r;
            default:           st_nxt.rdata_r = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r          <= '0;
         st_r.port_a_r <= `OCDIO_PORT_RST;
         st_r.port_b_r <= `OCDIO_PORT_RST;
         st_r.port_c_r <= `OCDIO_PORT_RST;
         st_r.irq_en_r <= `OCDIO_EN_RST;
         st_r.prev_r   <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata_r;
   assign o_irq   = |st_r.pend_r || st_r.ext_pend_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_RESET_PORTS: assert property (@(posedge i_clk_sys)
      i_rst |=> latch == 24'hffffff)
      else $error("ports not all ones after reset");
   AST_PORT_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.wr && i_bus.addr == 3'h0 |=> st_r.port_a_r == $past(i_bus.wdata))
      else $error("port A write not latched");
   AST_DRIVE_LOW: assert property (@(posedge i_clk_sys)
      o_io_channels_oe_n == latch && o_io_channels == '0)
      else $error("driver does not follow latch");
   AST_READ_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.rd && i_bus.addr == 3'h2 |=> (o_rdata & ~$past(st_r.port_c_r)) == 0)
      else $error("masked channel read nonzero");
   AST_NO_SRC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !st_r.port_c_r[0] && !st_r.pend_r[0] && !ack[0] |=> !st_r.pend_r[0])
      else $error("output channel raised status");
   AST_STICKY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      st_r.pend_r[3] && !ack[3] |=> st_r.pend_r[3])
      else $error("status dropped without ack");
   AST_ACK_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      st_r.pend_r[1] && ack[1] && !cond[1] |=> !st_r.pend_r[1])
      else $error("acknowledged status not cleared");
   AST_LEVEL_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      ack[2] && cond[2] |=> st_r.pend_r[2] == $past(st_r.pend_r[2] || src_on[2]))
      else $error("level source lost on ack");
   AST_IRQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_irq == (st_r.pend_r != 8'h00 || st_r.ext_pend_r))
      else $error("request does not match status");
   AST_EXT_MODE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.wr && i_bus.addr == 3'h6 |=> st_r.ext_en_r == $past(i_bus.wdata[6]))
      else $error("external enable not written");

   AST_PORT_B_WRITE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && i_bus.addr == `OCDIO_OFS_PORT_B
      |=> st_r.port_b_r == $past(i_bus.wdata))
      else $error("port B write not latched");

   AST_PORT_C_WRITE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && i_bus.addr == `OCDIO_OFS_PORT_C
      |=> st_r.port_c_r == $past(i_bus.wdata))
      else $error("port C write not latched");

   AST_EN_WRITE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && i_bus.addr == `OCDIO_OFS_IRQ_EN
      |=> st_r.irq_en_r == $past(i_bus.wdata))
      else $error("enable write not latched");

   AST_MODE_WRITE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && i_bus.addr == `OCDIO_OFS_MODE
      |=> {st_r.ext_mode_r, st_r.up_mode_r, st_r.lo_mode_r}
          == $past(i_bus.wdata[5:0]))
      else $error("mode fields not latched");

   AST_READ_A: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.rd && i_bus.addr == `OCDIO_OFS_PORT_A
      |=> o_rdata == $past(sync_ab_r[7:0] & st_r.port_a_r))
      else $error("port A read wrong");

   AST_READ_B: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.rd && i_bus.addr == `OCDIO_OFS_PORT_B
      |=> o_rdata == $past(sync_ab_r[15:8] & st_r.port_b_r))
      else $error("port B read wrong");

   AST_READ_STATUS: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.rd && i_bus.addr == `OCDIO_OFS_STATUS
      |=> o_rdata == $past(st_r.pend_r))
      else $error("status read wrong");

   AST_READ_MODE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.rd && i_bus.addr == `OCDIO_OFS_MODE
      |=> o_rdata[7:6] == $past({st_r.ext_pend_r, st_r.ext_en_r}))
      else $error("mode read wrong");

   AST_READ_HOLE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.rd && (i_bus.addr == `OCDIO_OFS_HOLE_LO ||
                   i_bus.addr == `OCDIO_OFS_HOLE_HI)
      |=> o_rdata == 8'h00)
      else $error("unused offset read nonzero");

   AST_WRITE_HOLE: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && (i_bus.addr == `OCDIO_OFS_HOLE_LO ||
                   i_bus.addr == `OCDIO_OFS_HOLE_HI)
      |=> $stable({latch, st_r.irq_en_r, st_r.ext_en_r, st_r.ext_mode_r,
                   st_r.up_mode_r, st_r.lo_mode_r}))
      else $error("unused offset write changed state");

   AST_RDATA_HOLD: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      !i_bus.rd |=> $stable(o_rdata))
      else $error("read data changed without read");

   AST_RESET_IRQ: assert property (@(posedge i_clk_sys)
      i_rst |=> !o_irq && o_rdata == 8'h00)
      else $error("request or read data live after reset");

   AST_IRQ_AFTER_ACK: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      i_bus.wr && i_bus.addr == `OCDIO_OFS_STATUS &&
      (st_r.pend_r & ~i_bus.wdata) != 8'h00 |=> o_irq)
      else $error("request dropped with status left");

   // Independent restatement of the mode codes, per Port C source
   generate
      for (genvar k = 0; k < 8; k++) begin : g_src_chk
         logic [1:0] m_chk;
         logic       hit;
         assign m_chk = (k < 4) ? st_r.lo_mode_r : st_r.up_mode_r;
         assign hit   = m_chk[1] ?
            (live_c[k] != st_r.prev_r[k] && live_c[k] == m_chk[0]) :
            (live_c[k] == m_chk[0]);

         AST_SRC_SET: assert property (@(posedge i_clk_sys)
            disable iff (i_rst)
            st_r.port_c_r[k] && st_r.irq_en_r[k] && hit
            |=> st_r.pend_r[k])
            else $error("Port C condition did not set status");

         AST_SRC_STICKY: assert property (@(posedge i_clk_sys)
            disable iff (i_rst)
            st_r.pend_r[k] && !ack[k] |=> st_r.pend_r[k])
            else $error("Port C status dropped without ack");
      end
   endgenerate

   // Same restatement for the external source
   logic ext_hit;
   assign ext_hit = st_r.ext_mode_r[1] ?
      (sync_r[8] != st_r.prev_r[8] && sync_r[8] == st_r.ext_mode_r[0]) :
      (sync_r[8] == st_r.ext_mode_r[0]);

   AST_EXT_SET: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      st_r.ext_en_r && ext_hit |=> st_r.ext_pend_r)
      else $error("external condition did not set status");

   AST_EXT_STICKY: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      st_r.ext_pend_r && !ack[8] |=> st_r.ext_pend_r)
      else $error("external status dropped without ack");

   AST_EXT_CLEAR: assert property (@(posedge i_clk_sys)
      disable iff (i_rst)
      st_r.ext_pend_r && ack[8] && !ext_hit |=> !st_r.ext_pend_r)
      else $error("external status not cleared");

   ////////////////////////////////////////////////////////////////////////
   // Scenario coverage
   COV_IRQ: cover property (@(posedge i_clk_sys) $rose(o_irq));
   COV_REARM: cover property (@(posedge i_clk_sys)
      ack[7] && cond[7] && st_r.pend_r[7]);
   COV_EXT: cover property (@(posedge i_clk_sys) $rose(st_r.ext_pend_r));
   COV_ACK: cover property (@(posedge i_clk_sys) $fell(o_irq));
endmodule : ocdio_top

// file: ocdio_periph.sv
// Peripheral side of the channel pins: pull-ups and open-collector drivers
`timescale 1ns/1ps
module ocdio_periph (
   // Device side of the pins
   input  wire logic [23:0] i_oe_n,
   // Peripheral drivers, one pulls its line low when set
   input  wire logic [23:0] i_pull_low,
   input  wire logic        i_ext_low,
   // Resolved line levels
   output logic [23:0]      o_level,
   output logic             o_ext
);
   // A released line rises to the pull-up level
   assign o_level = i_oe_n & ~i_pull_low;
   // The external line stays high unless the peripheral pulls it low
   assign o_ext   = ~i_ext_low;
endmodule : ocdio_periph

// file: ocdio_top_tb.sv
// Self-checking testbench for the digital I/O block
`timescale 1ns/1ps
module ocdio_top_tb;
   import ocdio_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   ocdio_bus_s  bus = '0;
   logic [7:0]  rdata;
   logic        irq;
   logic [23:0] lvl, drv, oe_n, pull = '0;
   logic        ext, ext_low = 1'b0;
   int          mismatches = 0;
   int          n_compared = 0;

   initial begin
      forever #2.5 clk = ~clk;
   end

   ocdio_top i_dut (.i_clk_sys(clk), .i_rst(rst), .i_bus(bus),
      .o_rdata(rdata), .o_irq(irq), .i_io_channels(lvl),
      .o_io_channels(drv), .o_io_channels_oe_n(oe_n), .i_ext_irq(ext));
   ocdio_periph i_per (.i_oe_n(oe_n), .i_pull_low(pull),
      .i_ext_low(ext_low), .o_level(lvl), .o_ext(ext));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk({16'h0000, rdata}, {16'h0000, exp});
   endtask : rchk

   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle

   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(oe_n, 24'hffffff);
      chk({23'h0, irq}, 24'h0);
      rchk(3'h0, 8'hff);
      rchk(3'h1, 8'hff);
      rchk(3'h2, 8'hff);
      rchk(3'h5, 8'h00);
      rchk(3'h6, 8'h00);
      rchk(3'h3, 8'h00);
      // Port latches drive the pins; reads mask latched zeros
      wr(3'h0, 8'ha5);
      wr(3'h1, 8'h3c);
      #1;
      chk(oe_n, 24'hff3ca5);
      chk(drv, 24'h000000);
      pull <= 24'h000021;
      settle();
      rchk(3'h0, 8'h84);
      rchk(3'h1, 8'h3c);
      // Port C: upper nibble low level, lower nibble rising edge
      pull <= 24'h000000;
      wr(3'h6, 8'h03);
      wr(3'h5, 8'h81);
      pull <= 24'hc10000;
      settle();
      rchk(3'h7, 8'h80);
      chk({23'h0, irq}, 24'h1);
      wr(3'h7, 8'h80);
      settle();
      rchk(3'h7, 8'h80);
      pull <= 24'h000000;
      settle();
      rchk(3'h7, 8'h81);
      wr(3'h7, 8'h01);
      settle();
      rchk(3'h7, 8'h80);
      chk({23'h0, irq}, 24'h1);
      wr(3'h7, 8'h80);
      settle();
      rchk(3'h7, 8'h00);
      chk({23'h0, irq}, 24'h0);
      // A latched zero on an enabled source never interrupts
      wr(3'h2, 8'h7f);
      settle();
      rchk(3'h7, 8'h00);
      wr(3'h2, 8'hff);
      settle();
      // Channel 23 shows its old low level while the synchronisers catch up
      wr(3'h7, 8'h80);
      settle();
      rchk(3'h7, 8'h00);
      // External source, falling edge
      wr(3'h6, 8'h63);
      ext_low <= 1'b1;
      settle();
      rchk(3'h6, 8'he3);
      chk({23'h0, irq}, 24'h1);
      wr(3'h6, 8'he3);
      settle();
      rchk(3'h6, 8'h63);
      chk({23'h0, irq}, 24'h0);
      // Upper nibble active high with idle-high lines
      wr(3'h6, 8'h07);
      settle();
      rchk(3'h7, 8'h80);
      report_and_stop();
   end
endmodule : ocdio_top_tb
